// *** verif/card_model.sv ***
// Behavioural 16-bit card sitting in the socket: detect, ready, battery, ring pins.
// Assumes the bench calls setPins from its own sequence; pins change after a clk edge.
`timescale 1ns/100ps

module card_model (
  input wire logic clk,
  output logic cardDetectA,
  output logic cardDetectB,
  output logic readyIn,
  output logic batteryLowIn,
  output logic cardStatusChangedSig,
  output logic batteryVoltRingPin
);
  initial
  begin
    {cardDetectA, cardDetectB, readyIn, batteryLowIn} = 4'h0;
    {cardStatusChangedSig, batteryVoltRingPin} = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slow cards settle lag cycles late; all six pins move on one edge
  task automatic setPins(input logic [5:0] v, input int lag);
    repeat (lag + 1) @(posedge clk);
    {cardDetectA, cardDetectB, readyIn, batteryLowIn} <= v[5:2];
    {cardStatusChangedSig, batteryVoltRingPin} <= v[1:0];
  endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the status-change flags and interrupt routing.
// Assumes card_model drives the socket pins and the config header is on the path.
`timescale 1ns/100ps
`include "csc_irq_cfg.svh"

module testbench;
  logic clk;
  logic nrst;
  logic [11:0] regAddr;
  logic regWrite;
  logic regRead;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regRdValid;
  logic [4:0] mode;
  logic cardDetectA;
  logic cardDetectB;
  logic readyIn;
  logic batteryLowIn;
  logic cardStatusChangedSig;
  logic batteryVoltRingPin;
  logic [15:0] isaIrq;
  logic smiReq;
  logic hostBusIrq;
  logic [31:0] v;
  int n_errors = 0;
  int samples_checked = 0;

  card_status_change_irq dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .clearModeWrite1(mode[4]), .changeToHostBusRoute(mode[3]), .diagChangeRouteBit(mode[2]),
    .cardKindSel(mode[1]), .ringFunctionEnable(mode[0]), .cardDetectA(cardDetectA),
    .cardDetectB(cardDetectB), .readyIn(readyIn), .batteryLowIn(batteryLowIn),
    .cardStatusChangedSig(cardStatusChangedSig), .batteryVoltRingPin(batteryVoltRingPin),
    .isaIrq(isaIrq), .smiReq(smiReq), .hostBusIrq(hostBusIrq));

  card_model card (.clk(clk), .cardDetectA(cardDetectA), .cardDetectB(cardDetectB),
    .readyIn(readyIn), .batteryLowIn(batteryLowIn), .cardStatusChangedSig(cardStatusChangedSig),
    .batteryVoltRingPin(batteryVoltRingPin));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [17:0] e, input logic [17:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setMode(input logic [4:0] m);
    @(posedge clk);
    mode <= m;
  endtask

  task automatic regWr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Answer lands one edge after the read edge
  task automatic expectRd(input string what, input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    check("read valid", 18'h00001, {17'h00000, regRdValid});
    check(what, {10'h000, e}, {10'h000, regRdata});
  endtask

  function automatic logic [17:0] routeExp(input logic [3:0] sel, input logic hostEn,
    input logic diag);
    logic [15:0] isa;
    isa = 16'h0000;
    if (hostEn || (sel == `CSC_ROUTE_NONE && diag))
      return 18'h00001;
    if (sel == `CSC_ROUTE_SMI)
      return 18'h00002;
    if (sel == `CSC_ROUTE_NONE)
      return 18'h00000;
    isa[sel] = 1'b1;
    return {isa, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    regAddr = 12'h000;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
    mode = 5'h00;
    void'($urandom(66814));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    expectRd("flags reset", `CSC_FLAGS_OFS, 8'h00);
    expectRd("config reset", `CSC_CONFIG_OFS, 8'h00);
    v = $urandom;
    regWr(`CSC_CONFIG_OFS, v[7:0]);
    expectRd("config rw", `CSC_CONFIG_OFS, v[7:0]);
    regWr(12'h806, 8'hFF);
    expectRd("unmapped", 12'h806, 8'h00);
    regWr(`CSC_CONFIG_OFS, 8'h00);
    card.setPins(6'b111110, 1);
    idle(4);
    expectRd("masked flags", `CSC_FLAGS_OFS, 8'h00);
    check("masked out", 18'h00000, {isaIrq, smiReq, hostBusIrq});
    card.setPins(6'b000000, 0);
    // Every route code against host-route and diagnostic bits
    for (int i = 0; i < 64; i++)
    begin
      setMode({2'b00, i[5], 2'b00} | {1'b0, i[4], 3'b000});
      regWr(`CSC_CONFIG_OFS, {i[3:0], 4'h8});
      card.setPins({~i[0], 5'h00}, i % 3);
      idle(4);
      check("route", routeExp(i[3:0], i[4], i[5]), {isaIrq, smiReq, hostBusIrq});
      // Write of ones must not clear while read-clear mode is selected
      regWr(`CSC_FLAGS_OFS, 8'hFF);
      expectRd("detect flag", `CSC_FLAGS_OFS, 8'h08);
      idle(2);
      check("out after read", 18'h00000, {isaIrq, smiReq, hostBusIrq});
    end
    setMode(5'b10000);
    regWr(`CSC_CONFIG_OFS, 8'h36);
    card.setPins(6'b001100, 2);
    idle(4);
    check("ready out", routeExp(4'h3, 1'b0, 1'b0), {isaIrq, smiReq, hostBusIrq});
    expectRd("ready bat", `CSC_FLAGS_OFS, 8'h06);
    expectRd("no read clear", `CSC_FLAGS_OFS, 8'h06);
    regWr(`CSC_FLAGS_OFS, 8'h04);
    expectRd("w1c one", `CSC_FLAGS_OFS, 8'h02);
    regWr(`CSC_FLAGS_OFS, 8'h02);
    idle(2);
    check("out w1c", 18'h00000, {isaIrq, smiReq, hostBusIrq});
    regWr(`CSC_CONFIG_OFS, 8'h0E);
    card.setPins(6'b101100, 0);
    idle(4);
    regWr(`CSC_CONFIG_OFS, 8'h06);
    expectRd("mask clears", `CSC_FLAGS_OFS, 8'h00);
    // Battery-dead level follows the pin while enabled
    for (int j = 0; j < 8; j++)
    begin
      v = $urandom;
      regWr(`CSC_CONFIG_OFS, {7'h00, v[0]});
      card.setPins({4'b1011, v[1], 1'b0}, 0);
      idle(3);
      expectRd("bat dead", `CSC_FLAGS_OFS, {7'h00, v[0] & v[1]});
    end
    setMode(5'b10010);
    regWr(`CSC_CONFIG_OFS, 8'h06);
    card.setPins(6'b100000, 0);
    card.setPins(6'b101100, 0);
    idle(4);
    expectRd("io card", `CSC_FLAGS_OFS, 8'h00);
    // I/O card without ring latches status-changed assertion
    regWr(`CSC_CONFIG_OFS, 8'h01);
    card.setPins(6'b101110, 0);
    idle(3);
    expectRd("io status", `CSC_FLAGS_OFS, 8'h01);
    card.setPins(6'b101100, 0);
    regWr(`CSC_FLAGS_OFS, 8'h01);
    expectRd("io status clear", `CSC_FLAGS_OFS, 8'h00);
    setMode(5'b10011);
    regWr(`CSC_CONFIG_OFS, 8'h01);
    card.setPins(6'b100001, 0);
    idle(3);
    expectRd("ring on", `CSC_FLAGS_OFS, 8'h01);
    card.setPins(6'b100000, 0);
    idle(3);
    expectRd("ring off", `CSC_FLAGS_OFS, 8'h00);
    close_out();
  end

  // Main sequence needs about 1100 cycles
  initial
  begin
    #(20 * 4000);
    n_errors++;
    close_out();
  end
endmodule

// *** verilog/card_event_detect.sv ***
// Edge and change detector for the socket's event pins, one lane per pin.
// Assumes pins already synchronous to clk.
`timescale 1ns/100ps
`include "csc_irq_cfg.svh"

module card_event_detect #(
  parameter int N = `CSC_EV_COUNT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] change
);

  if (N < 1)
  begin : gCheck
    $error("card_event_detect needs at least one lane");
  end

  // Pins are sampled after reset release, so a card already present
  // does not look like a fresh change.
  logic primed_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      primed_r <= 1'b0;
    else
      primed_r <= 1'b1;
  end

  for (genvar i = 0; i < N; i++)
  begin : gLane
    logic prev_r;
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        prev_r <= 1'b0;
      else
        prev_r <= level[i];
    end
    assign rise[i] = primed_r & level[i] & ~prev_r;
    assign change[i] = primed_r & (level[i] ^ prev_r);
  end

endmodule

// *** verilog/card_status_change_irq.sv ***
// Status-change flags and interrupt configuration for one 16-bit card socket.
// Assumes a byte register port with one-cycle read and write strobes, and
// loose mode bits held stable by the surrounding socket registers.
`timescale 1ns/100ps
`include "csc_irq_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - A masked source reads zero in the status-change register.
// - An unmasked active source sets its flag and interrupts the host.
// - Flags clear on read or on write of one, per clear-mode input.
// - Status-change bits seven to four always read zero.
// - Bit three sets on any card-detect level change.
// - Memory card: bit two sets on READY rising edge.
// - I/O card: bits two and one held at zero.
// - Memory card: bit one sets on battery-low warning.
// - Memory card: bit zero follows the status-changed signal level.
// - I/O card with ring enabled: bit zero follows ring indicate.
// - Route field selects none, IRQ1, SMI or IRQn.
// - Field zero with diagnostic bit routes to host bus always.
// - Field zero without diagnostic bit: host bus only if enabled.
// - Config bit three gates card-detect change interrupts.
// - Config bit two gates READY rising interrupts, default off.
// - Config bit one gates battery-warning interrupts, default off.
// - Config bit zero gates battery-dead or status-changed interrupts.
// - Route enable sends interrupts to host bus, else field routes.
// - Card kind selects memory or I/O meaning of flags.
// - Ring enable turns the shared pin into ring indicate on an I/O card; a memory card ignores it.
module card_status_change_irq #(
  parameter int IRQ_LINES = `CSC_ISA_LINES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`CSC_ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regRdValid,
  input wire logic clearModeWrite1,
  input wire logic changeToHostBusRoute,
  input wire logic diagChangeRouteBit,
  input wire logic cardKindSel,
  input wire logic ringFunctionEnable,
  input wire logic cardDetectA,
  input wire logic cardDetectB,
  input wire logic readyIn,
  input wire logic batteryLowIn,
  input wire logic cardStatusChangedSig,
  input wire logic batteryVoltRingPin,
  output logic [IRQ_LINES-1:0] isaIrq,
  output logic smiReq,
  output logic hostBusIrq
);

  if (IRQ_LINES < `CSC_ISA_LINES)
  begin : gCheck
    $error("card_status_change_irq needs sixteen ISA lines");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic rdFlags;
  logic wrFlags;
  logic wrConfig;

  assign rdFlags = regRead && regAddr == `CSC_FLAGS_OFS;
  assign wrFlags = regWrite && regAddr == `CSC_FLAGS_OFS;
  assign wrConfig = regWrite && regAddr == `CSC_CONFIG_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  logic [7:0] config_r;
  logic [`CSC_SRC_MSB:0] srcEnable;
  logic [3:0] routeSel;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      config_r <= `CSC_CONFIG_RST;
    else if (wrConfig)
      config_r <= regWdata;
  end

  assign srcEnable = config_r[`CSC_SRC_MSB:0];
  assign routeSel = config_r[`CSC_ROUTE_MSB:`CSC_ROUTE_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Event detection

  logic [`CSC_EV_COUNT-1:0] evLevel;
  logic [`CSC_EV_COUNT-1:0] evRise;
  logic [`CSC_EV_COUNT-1:0] evChange;

  assign evLevel[`CSC_EV_DETECT_A] = cardDetectA;
  assign evLevel[`CSC_EV_DETECT_B] = cardDetectB;
  assign evLevel[`CSC_EV_READY] = readyIn;
  assign evLevel[`CSC_EV_BATLOW] = batteryLowIn;
  assign evLevel[`CSC_EV_STATUS] = cardStatusChangedSig;

  card_event_detect #(
    .N(`CSC_EV_COUNT)
  ) uDetect (
    .clk(clk),
    .nrst(nrst),
    .level(evLevel),
    .rise(evRise),
    .change(evChange)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source events

  logic ioCard;
  logic levelBit0;
  logic [`CSC_SRC_MSB:0] setEvent;
  logic [`CSC_SRC_MSB:0] keepMask;

  assign ioCard = cardKindSel;
  // battery-dead level on memory card; ring state on I/O card
  // shared pin used only with ring enabled
  assign levelBit0 = !ioCard || ringFunctionEnable;

  always_comb
  begin
    setEvent = '0;
    setEvent[`CSC_BIT_DETECT] = evChange[`CSC_EV_DETECT_A] | evChange[`CSC_EV_DETECT_B];
    // READY low to high, memory card only
    setEvent[`CSC_BIT_READY] = evRise[`CSC_EV_READY] & !ioCard;
    setEvent[`CSC_BIT_BATLOW] = evRise[`CSC_EV_BATLOW] & !ioCard;
    // I/O card without ring latches status-changed assertion
    setEvent[`CSC_BIT_BATDEAD] = evRise[`CSC_EV_STATUS] & !levelBit0;
  end

  always_comb
  begin
    keepMask = srcEnable;
    // I/O card forces ready and battery flags low
    if (ioCard)
    begin
      keepMask[`CSC_BIT_READY] = 1'b0;
      keepMask[`CSC_BIT_BATLOW] = 1'b0;
    end
    if (levelBit0)
      keepMask[`CSC_BIT_BATDEAD] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags

  logic [`CSC_SRC_MSB:0] latch_r;
  logic [`CSC_SRC_MSB:0] latch_nxt;
  logic [`CSC_SRC_MSB:0] clearVec;
  logic [`CSC_SRC_MSB:0] statusView;
  logic levelValue;

  always_comb
  begin
    clearVec = '0;
    if (rdFlags && !clearModeWrite1)
      clearVec = '1;
    else if (wrFlags && clearModeWrite1)
      clearVec = regWdata[`CSC_SRC_MSB:0];
  end

  // new events set; set wins over a same-cycle clear
  assign latch_nxt = ((latch_r & ~clearVec) | setEvent) & keepMask;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      latch_r <= `CSC_LATCH_RST;
    else
      latch_r <= latch_nxt;
  end

  assign levelValue = ioCard ? batteryVoltRingPin : cardStatusChangedSig;

  always_comb
  begin
    statusView = latch_r & keepMask;
    if (levelBit0)
      statusView[`CSC_BIT_BATDEAD] = levelValue & srcEnable[`CSC_BIT_BATDEAD];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regRdata <= `CSC_READ_NONE;
    else if (regRead)
    begin
      case (regAddr)
        `CSC_FLAGS_OFS: regRdata <= {`CSC_RSVD_ZERO, statusView};
        `CSC_CONFIG_OFS: regRdata <= config_r;
        default: regRdata <= `CSC_READ_NONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      regRdValid <= 1'b0;
    else
      regRdValid <= regRead;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing

  logic pending;

  // any shown flag keeps the request up
  assign pending = |statusView;

  change_irq_router #(
    .IRQ_LINES(IRQ_LINES)
  ) uRouter (
    .clk(clk),
    .nrst(nrst),
    .pending(pending),
    .routeSel(routeSel),
    .hostRoute(changeToHostBusRoute),
    .diagBit(diagChangeRouteBit),
    .isaIrq(isaIrq),
    .smiReq(smiReq),
    .hostBusIrq(hostBusIrq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  masked_reads_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (rdFlags && !config_r[`CSC_BIT_DETECT]) |=> regRdata[`CSC_BIT_DETECT] == 1'b0)
    else $error("masked detect flag read as one");

  detect_flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (evChange[`CSC_EV_DETECT_B] && srcEnable[`CSC_BIT_DETECT] && !wrConfig)
    |=> latch_r[`CSC_BIT_DETECT])
    else $error("detect change not latched");

  ready_flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(readyIn) && !ioCard && srcEnable[`CSC_BIT_READY] && !wrConfig
    && $past(nrst)) |=> latch_r[`CSC_BIT_READY])
    else $error("ready rise not latched");

  io_flags_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (rdFlags && ioCard) |=> regRdata[`CSC_BIT_READY:`CSC_BIT_BATLOW] == 2'b00)
    else $error("I/O card shows ready or battery flag");

  reserved_bits_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    rdFlags |=> regRdValid && regRdata[7:4] == `CSC_RSVD_ZERO)
    else $error("reserved status bits not zero");

  read_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (rdFlags && !clearModeWrite1 && setEvent == '0) |=> latch_r == '0)
    else $error("read did not clear flags");

  write_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (wrFlags && clearModeWrite1 && regWdata[`CSC_BIT_DETECT]
    && !setEvent[`CSC_BIT_DETECT]) |=> !latch_r[`CSC_BIT_DETECT])
    else $error("write of one did not clear detect flag");

  dead_level_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (rdFlags && !ioCard && srcEnable[`CSC_BIT_BATDEAD])
    |=> regRdata[`CSC_BIT_BATDEAD] == $past(cardStatusChangedSig))
    else $error("bit zero does not follow status-changed level");

  host_route_a: assert property (@(posedge clk) disable iff (!nrst)
    (pending && changeToHostBusRoute) |=> hostBusIrq && isaIrq == '0)
    else $error("route enable did not reach host bus");

  diag_route_a: assert property (@(posedge clk) disable iff (!nrst)
    (pending && routeSel == `CSC_ROUTE_NONE && diagChangeRouteBit) |=> hostBusIrq)
    else $error("diagnostic bit did not route to host bus");

  smi_route_a: assert property (@(posedge clk) disable iff (!nrst)
    (pending && !changeToHostBusRoute && routeSel == `CSC_ROUTE_SMI)
    |=> smiReq && !hostBusIrq && isaIrq == '0)
    else $error("SMI select not honoured");

  irq_release_a: assert property (@(posedge clk) disable iff (!nrst)
    !pending |=> !hostBusIrq && !smiReq && isaIrq == '0)
    else $error("interrupt held with no flag set");

endmodule

// *** verilog/change_irq_router.sv ***
// Steers the pending status-change request to ISA lines, SMI or host bus.
// Assumes pending is already masked; outputs are registered levels.
`timescale 1ns/100ps
`include "csc_irq_cfg.svh"

module change_irq_router #(
  parameter int IRQ_LINES = `CSC_ISA_LINES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pending,
  input wire logic [3:0] routeSel,
  input wire logic hostRoute,
  input wire logic diagBit,
  output logic [IRQ_LINES-1:0] isaIrq,
  output logic smiReq,
  output logic hostBusIrq
);

  if (IRQ_LINES < `CSC_ISA_LINES)
  begin : gCheck
    $error("change_irq_router needs sixteen ISA lines");
  end

  csc_irq_pkg::route_kind_t kind;
  logic [IRQ_LINES-1:0] oneHot;

  always_comb
  begin
    kind = csc_irq_pkg::ROUTE_OFF;
    if (hostRoute)
      kind = csc_irq_pkg::ROUTE_HOST;
    else if (routeSel == `CSC_ROUTE_NONE)
    begin
      if (diagBit)
        kind = csc_irq_pkg::ROUTE_HOST;
      else
        kind = csc_irq_pkg::ROUTE_OFF;
    end
    else if (routeSel == `CSC_ROUTE_SMI)
      kind = csc_irq_pkg::ROUTE_SMI;
    else
      kind = csc_irq_pkg::ROUTE_ISA;
  end

  assign oneHot = {{(IRQ_LINES-1){1'b0}}, 1'b1} << routeSel;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      isaIrq <= '0;
      smiReq <= 1'b0;
      hostBusIrq <= 1'b0;
    end
    else
    begin
      isaIrq <= (pending && kind == csc_irq_pkg::ROUTE_ISA) ? oneHot : '0;
      smiReq <= pending && kind == csc_irq_pkg::ROUTE_SMI;
      hostBusIrq <= pending && kind == csc_irq_pkg::ROUTE_HOST;
    end
  end

endmodule

// *** verilog/csc_irq_cfg.svh ***
// Offsets, field positions and reset values of the status-change interrupt block.
// Assumes inclusion by bare name from the verilog/ folder.
`ifndef CSC_IRQ_CFG_SVH
`define CSC_IRQ_CFG_SVH

`define CSC_ADDR_W 12
`define CSC_FLAGS_OFS 12'h804
`define CSC_CONFIG_OFS 12'h805
`define CSC_FLAGS_RST 8'h00
`define CSC_LATCH_RST 4'h0
`define CSC_CONFIG_RST 8'h00
`define CSC_RSVD_ZERO 4'h0
`define CSC_READ_NONE 8'h00

`define CSC_BIT_DETECT 3
`define CSC_BIT_READY 2
`define CSC_BIT_BATLOW 1
`define CSC_BIT_BATDEAD 0
`define CSC_SRC_MSB 3
`define CSC_ROUTE_MSB 7
`define CSC_ROUTE_LSB 4

`define CSC_ROUTE_NONE 4'h0
`define CSC_ROUTE_IRQ1 4'h1
`define CSC_ROUTE_SMI 4'h2

`define CSC_EV_DETECT_A 0
`define CSC_EV_DETECT_B 1
`define CSC_EV_READY 2
`define CSC_EV_BATLOW 3
`define CSC_EV_STATUS 4
`define CSC_EV_COUNT 5

`define CSC_ISA_LINES 16

`endif

// *** verilog/csc_irq_pkg.sv ***
// Types shared by the status-change interrupt block.
// Assumes nothing of its surroundings.
package csc_irq_pkg;

  typedef enum logic [1:0] {
    ROUTE_OFF,
    ROUTE_ISA,
    ROUTE_SMI,
    ROUTE_HOST
  } route_kind_t;

endpackage
